// ### core/cbh_cart_port.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - output latch keeps the last host byte and drives it on cartridge out lines
// - host reads the eight cartridge input lines as one byte
// - tristate line floats or drives the level of output bit 0
// - every write to output latch sets output-ready, even same value
// - acknowledge going low clears output-ready
// - input strobe pulse sets input-ready until host reads the input port
// - both ready flags are readable by the host
// - output direction holds one byte in its latch; input byte is read live, not captured at the strobe
// - serial transmitter waits to start a frame while clear-to-send is deasserted
module cbh_cart_port (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire cbh_pkg::cbh_bus_req_s bus_req,
	output logic [31:0]                rdata,
	output logic [7:0]                 cart_out_bits,
	input  wire logic [7:0]            cart_in_bits,
	output logic                       tristate_line_o,
	output logic                       tristate_line_oe_n,
	input  wire logic                  tristate_line_i,
	input  wire logic                  input_strobe_n,
	input  wire logic                  output_ack_n,
	output logic                       input_ready_flag,
	output logic                       output_ready_flag,
	output logic                       aux_tx,
	output logic                       aux_rts_n,
	input  wire logic                  aux_cts_n,
	output logic                       irq
);

	localparam int IRQ_W_L = cbh_pkg::IRQ_W;

	logic [7:0]  out_latch_ff;
	logic [15:0] tri_ctrl_ff;
	logic        tri_o_ff;
	logic        tri_oe_n_ff;
	logic        in_ready_ff;
	logic        out_ready_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [7:0]  in_s1_ff;
	logic [7:0]  in_s2_ff;
	logic [2:0]  strb_sync_ff;
	logic [2:0]  ack_sync_ff;
	logic [1:0]  cts_sync_ff;
	logic [1:0]  tri_sync_ff;
	logic [IRQ_W_L-1:0] irq_stat_ff;
	logic [IRQ_W_L-1:0] irq_mask_ff;
	logic [IRQ_W_L-1:0] irq_event;
	logic        irq_ff;
	logic        rts_ff;
	logic        rts_n_ff;
	logic [15:0] ser_div_ff;
	logic [7:0]  ser_hold_ff;
	logic [9:0]  ser_shift_ff;
	logic [3:0]  ser_bits_ff;
	logic [15:0] ser_baud_ff;
	logic        ser_done_ff;
	logic        aux_tx_ff;
	cbh_pkg::cbh_ser_state_e ser_state_ff;

	logic wr_out;
	logic wr_tri;
	logic wr_istat;
	logic wr_imask;
	logic wr_sctrl;
	logic wr_sdata;
	logic wr_sdiv;
	logic rd_in;
	logic strobe_fall;
	logic ack_fall;
	logic cts_ok;

	// address decode, one select per register
	assign wr_out   = bus_req.wr && (bus_req.addr == cbh_pkg::ADDR_OUT_LATCH);
	assign wr_tri   = bus_req.wr && (bus_req.addr == cbh_pkg::ADDR_TRI_CTRL);
	assign wr_istat = bus_req.wr && (bus_req.addr == cbh_pkg::ADDR_IRQ_STAT);
	assign wr_imask = bus_req.wr && (bus_req.addr == cbh_pkg::ADDR_IRQ_MASK);
	assign wr_sctrl = bus_req.wr && (bus_req.addr == cbh_pkg::ADDR_SER_CTRL);
	assign wr_sdata = bus_req.wr && (bus_req.addr == cbh_pkg::ADDR_SER_DATA);
	assign wr_sdiv  = bus_req.wr && (bus_req.addr == cbh_pkg::ADDR_SER_DIV);
	assign rd_in    = bus_req.rd && (bus_req.addr == cbh_pkg::ADDR_IN_BYTE);

	// pin synchronisers; stage one feeds only stage two
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			in_s1_ff     <= 8'h00;
			in_s2_ff     <= 8'h00;
			strb_sync_ff <= 3'h7;
			ack_sync_ff  <= 3'h7;
			cts_sync_ff  <= 2'h3;
			tri_sync_ff  <= 2'h3;
		end
		else
		begin
			in_s1_ff     <= cart_in_bits;
			in_s2_ff     <= in_s1_ff;
			strb_sync_ff <= {strb_sync_ff[1:0], input_strobe_n};
			ack_sync_ff  <= {ack_sync_ff[1:0], output_ack_n};
			cts_sync_ff  <= {cts_sync_ff[0], aux_cts_n};
			tri_sync_ff  <= {tri_sync_ff[0], tristate_line_i};
		end
	end

	// edges are taken between stages two and three only
	assign strobe_fall = strb_sync_ff[2] && !strb_sync_ff[1];
	assign ack_fall    = ack_sync_ff[2] && !ack_sync_ff[1];
	assign cts_ok      = !cts_sync_ff[1];

	// output latch and its copy of bit 0 for the tristate pin
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_latch_ff <= cbh_pkg::RST_OUT_LATCH;
			tri_o_ff     <= 1'b0;
		end
		else if (wr_out)
		begin
			out_latch_ff <= bus_req.wdata[7:0];
			tri_o_ff     <= bus_req.wdata[0];
		end
	end

	// tristate control; oe_n low means the pin is driven
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tri_ctrl_ff <= cbh_pkg::RST_TRI_CTRL;
			tri_oe_n_ff <= 1'b1;
		end
		else if (wr_tri)
		begin
			tri_ctrl_ff <= bus_req.wdata[15:0];
			tri_oe_n_ff <= !bus_req.wdata[cbh_pkg::TRI_DRIVE_BIT];
		end
	end

	// transmit slot full flag; a write beats a coinciding ack
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			out_ready_ff <= 1'b0;
		else if (wr_out)
			out_ready_ff <= 1'b1;
		else if (ack_fall)
			out_ready_ff <= 1'b0;
	end

	// receive slot flag; a strobe in the read cycle is not lost
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			in_ready_ff <= 1'b0;
		else if (strobe_fall)
			in_ready_ff <= 1'b1;
		else if (rd_in)
			in_ready_ff <= 1'b0;
	end

	// sticky event bits, write one to clear, set wins
	assign irq_event[cbh_pkg::IRQ_IN_READY] = strobe_fall;
	assign irq_event[cbh_pkg::IRQ_OUT_ACK]  = ack_fall && !wr_out;
	assign irq_event[cbh_pkg::IRQ_SER_DONE] = ser_done_ff;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_stat_ff <= cbh_pkg::RST_IRQ;
		else if (wr_istat)
			irq_stat_ff <= (irq_stat_ff & ~bus_req.wdata[IRQ_W_L-1:0]) | irq_event;
		else
			irq_stat_ff <= irq_stat_ff | irq_event;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_mask_ff <= cbh_pkg::RST_IRQ;
		else if (wr_imask)
			irq_mask_ff <= bus_req.wdata[IRQ_W_L-1:0];
	end

	// registered so the interrupt pin comes from a flop
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
	end

	// serial control: request-to-send and baud divisor
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rts_ff   <= 1'b0;
			rts_n_ff <= 1'b1;
		end
		else if (wr_sctrl)
		begin
			rts_ff   <= bus_req.wdata[cbh_pkg::SER_RTS_BIT];
			// own flop for the pin, so no inverter sits after it
			rts_n_ff <= !bus_req.wdata[cbh_pkg::SER_RTS_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ser_div_ff <= cbh_pkg::RST_SER_DIV;
		else if (wr_sdiv)
			ser_div_ff <= bus_req.wdata[15:0];
	end

	// serial transmitter; a data write while busy is dropped
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ser_state_ff <= cbh_pkg::SER_IDLE;
			ser_hold_ff  <= 8'h00;
			ser_shift_ff <= 10'h3ff;
			ser_bits_ff  <= 4'h0;
			ser_baud_ff  <= 16'h0000;
			ser_done_ff  <= 1'b0;
			aux_tx_ff    <= 1'b1;
		end
		else
		begin
			ser_done_ff <= 1'b0;
			case (ser_state_ff)
				cbh_pkg::SER_IDLE:
				begin
					if (wr_sdata)
					begin
						ser_hold_ff  <= bus_req.wdata[7:0];
						ser_state_ff <= cbh_pkg::SER_WAIT_CTS;
					end
				end
				cbh_pkg::SER_WAIT_CTS:
				begin
					// nothing leaves the pin until clear-to-send is seen
					if (cts_ok)
					begin
						ser_shift_ff <= {1'b1, ser_hold_ff, 1'b0};
						ser_bits_ff  <= cbh_pkg::SER_FRAME_BITS;
						ser_baud_ff  <= ser_div_ff;
						aux_tx_ff    <= 1'b0;
						ser_state_ff <= cbh_pkg::SER_SEND;
					end
				end
				cbh_pkg::SER_SEND:
				begin
					if (ser_baud_ff != 16'h0000)
						ser_baud_ff <= ser_baud_ff - 16'h0001;
					else if (ser_bits_ff == 4'h1)
					begin
						aux_tx_ff    <= 1'b1;
						ser_done_ff  <= 1'b1;
						ser_state_ff <= cbh_pkg::SER_IDLE;
					end
					else
					begin
						// frame already started goes out whole even if cts drops
						ser_shift_ff <= {1'b1, ser_shift_ff[9:1]};
						aux_tx_ff    <= ser_shift_ff[1];
						ser_bits_ff  <= ser_bits_ff - 4'h1;
						ser_baud_ff  <= ser_div_ff;
					end
				end
				default:
					ser_state_ff <= cbh_pkg::SER_IDLE;
			endcase
		end
	end

	// read mux; unmapped and write-only addresses read zero
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		if (bus_req.rd)
		begin
			case (bus_req.addr)
				cbh_pkg::ADDR_IN_BYTE:
					nxt_rdata = {24'h000000, in_s2_ff};
				cbh_pkg::ADDR_STATUS:
				begin
					nxt_rdata[cbh_pkg::ST_IN_READY]  = in_ready_ff;
					nxt_rdata[cbh_pkg::ST_OUT_READY] = out_ready_ff;
					nxt_rdata[cbh_pkg::ST_TRI_IN]    = tri_sync_ff[1];
					nxt_rdata[cbh_pkg::ST_SER_BUSY]  = (ser_state_ff != cbh_pkg::SER_IDLE);
					nxt_rdata[cbh_pkg::ST_CTS]       = cts_ok;
				end
				cbh_pkg::ADDR_IRQ_STAT:
					nxt_rdata = {29'h0, irq_stat_ff};
				cbh_pkg::ADDR_IRQ_MASK:
					nxt_rdata = {29'h0, irq_mask_ff};
				cbh_pkg::ADDR_SER_CTRL:
					nxt_rdata = {31'h0, rts_ff};
				cbh_pkg::ADDR_SER_DIV:
					nxt_rdata = {16'h0000, ser_div_ff};
				default:
					nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= 32'h0000_0000;
		else
			rdata_ff <= nxt_rdata;
	end

	// every output straight from a flop
	assign rdata              = rdata_ff;
	assign cart_out_bits      = out_latch_ff;
	assign tristate_line_o    = tri_o_ff;
	assign tristate_line_oe_n = tri_oe_n_ff;
	assign input_ready_flag   = in_ready_ff;
	assign output_ready_flag  = out_ready_ff;
	assign aux_tx             = aux_tx_ff;
	assign aux_rts_n          = rts_n_ff;
	assign irq                = irq_ff;

endmodule : cbh_cart_port

// ### inc/cbh_pkg.sv
package cbh_pkg;

	// register byte addresses on the host bus
	localparam logic [31:0] ADDR_IN_BYTE    = 32'h1f40_0004;
	localparam logic [31:0] ADDR_TRI_CTRL   = 32'h1f50_0000;
	localparam logic [31:0] ADDR_OUT_LATCH  = 32'h1f6a_0000;
	localparam logic [31:0] ADDR_STATUS     = 32'h1f40_0008;
	localparam logic [31:0] ADDR_IRQ_STAT   = 32'h1f40_000c;
	localparam logic [31:0] ADDR_IRQ_MASK   = 32'h1f40_0010;
	localparam logic [31:0] ADDR_SER_CTRL   = 32'h1f40_0014;
	localparam logic [31:0] ADDR_SER_DATA   = 32'h1f40_0018;
	localparam logic [31:0] ADDR_SER_DIV    = 32'h1f40_001c;

	// status register fields
	localparam int ST_IN_READY  = 0;
	localparam int ST_OUT_READY = 1;
	localparam int ST_TRI_IN    = 2;
	localparam int ST_SER_BUSY  = 3;
	localparam int ST_CTS       = 4;

	// interrupt event fields, same layout in status and mask
	localparam int IRQ_IN_READY = 0;
	localparam int IRQ_OUT_ACK  = 1;
	localparam int IRQ_SER_DONE = 2;
	localparam int IRQ_W        = 3;

	// control fields
	localparam int TRI_DRIVE_BIT = 0;
	localparam int SER_RTS_BIT   = 0;

	// reset values
	localparam logic [7:0]  RST_OUT_LATCH = 8'h00;
	localparam logic [15:0] RST_TRI_CTRL  = 16'h0000;
	localparam logic [15:0] RST_SER_DIV   = 16'h00d9;
	localparam logic [2:0]  RST_IRQ       = 3'h0;

	// serial frame: start bit, eight data bits, stop bit
	localparam logic [3:0]  SER_FRAME_BITS = 4'ha;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} cbh_bus_req_s;

	typedef enum logic [1:0] {
		SER_IDLE,
		SER_WAIT_CTS,
		SER_SEND
	} cbh_ser_state_e;

endpackage : cbh_pkg

// ### sim/cbh_cart_model.sv
`timescale 1ns/1ps
module cbh_cart_model (
	input  wire logic       clk,
	input  wire logic       ack_en,
	input  wire logic [7:0] cart_out_bits,
	input  wire logic       output_ready_flag,
	input  wire logic       aux_rts_n,
	input  wire logic       tristate_line_o,
	input  wire logic       tristate_line_oe_n,
	output logic            tristate_line_i,
	output logic            aux_cts_n,
	output logic            output_ack_n = 1'b1,
	output logic            input_strobe_n = 1'b1,
	output logic [7:0]      cart_in_bits = 8'h00,
	output logic [7:0]      got = 8'h00
);
	int dly = 0;
	// jumper loops flow control back; released line is pulled up
	assign aux_cts_n = aux_rts_n;
	assign tristate_line_i = tristate_line_oe_n ? 1'b1 : tristate_line_o;
	// fetch only once the flag shows, cycling through reply delays of 0, 3 and 6 cycles
	always @(posedge clk)
		if (output_ready_flag && ack_en)
		begin
			repeat (dly) @(posedge clk);
			got <= cart_out_bits;
			output_ack_n <= 1'b0;
			repeat (2) @(posedge clk);
			output_ack_n <= 1'b1;
			repeat (4) @(posedge clk);
			dly = (dly + 3) % 9;
		end
	// byte settles on the lines before the strobe pulse
	task automatic send(input logic [7:0] b);
		cart_in_bits <= b;
		repeat (2) @(posedge clk);
		input_strobe_n <= 1'b0;
		repeat (2) @(posedge clk);
		input_strobe_n <= 1'b1;
	endtask : send
endmodule : cbh_cart_model

// ### sim/cbh_cart_port_checker.sv
`timescale 1ns/1ps
module cbh_port_chk (
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire cbh_pkg::cbh_bus_req_s bus_req,
	input wire logic [31:0]           rdata,
	input wire logic [7:0]            cart_out_bits,
	input wire logic                  input_strobe_n,
	input wire logic                  output_ack_n,
	input wire logic                  input_ready_flag,
	input wire logic                  output_ready_flag
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// decoded host strobes
	wire logic wr_lat = bus_req.wr && bus_req.addr == cbh_pkg::ADDR_OUT_LATCH;
	wire logic rd_in = bus_req.rd && bus_req.addr == cbh_pkg::ADDR_IN_BYTE;
	wire logic rd_st = bus_req.rd && bus_req.addr == cbh_pkg::ADDR_STATUS;
	// windows outlast the pin synchroniser
	sequence s_acked;
		$fell(output_ack_n) ##0 !wr_lat [*5];
	endsequence
	sequence s_quiet_rd;
		input_strobe_n [*6] ##0 rd_in;
	endsequence
	a_write_sets_ready: assert property (wr_lat |=> output_ready_flag
		&& cart_out_bits == $past(bus_req.wdata[7:0])) else $error("write lost");
	a_latch_holds: assert property (!wr_lat |=> $stable(cart_out_bits))
		else $error("latch moved");
	a_ack_clears: assert property (s_acked |=> !output_ready_flag)
		else $error("ack ignored");
	a_out_holds: assert property (output_ack_n [*6] ##0 output_ready_flag
		|=> output_ready_flag) else $error("out ready lost");
	a_strobe_sets: assert property ($fell(input_strobe_n) |-> ##[1:5] input_ready_flag)
		else $error("strobe missed");
	a_in_holds: assert property (input_ready_flag && !rd_in |=> input_ready_flag)
		else $error("in ready lost");
	a_read_clears: assert property (s_quiet_rd |=> !input_ready_flag)
		else $error("read kept ready");
	a_status_flags: assert property (rd_st |=> rdata[1:0]
		== {$past(output_ready_flag), $past(input_ready_flag)}) else $error("status bad");
endmodule : cbh_port_chk

bind cbh_cart_port cbh_port_chk u_chk (.*);

// ### sim/tb_cbh_cart_port.sv
`timescale 1ns/1ps
module tb_cbh_cart_port;
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] i;
	} cbh_row_s;
	cbh_row_s rows [3] = '{'{8'h5a, 8'ha5}, '{8'h00, 8'hff}, '{8'h81, 8'h3c}};
	logic clk, rst_n, ack_en, tristate_line_o, tristate_line_oe_n, tristate_line_i, irq;
	logic input_strobe_n, output_ack_n, input_ready_flag, output_ready_flag;
	logic aux_tx, aux_rts_n, aux_cts_n;
	logic [7:0] cart_out_bits, cart_in_bits, got;
	logic [31:0] rdata;
	cbh_pkg::cbh_bus_req_s bus_req;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	cbh_cart_port dut (.*);
	cbh_cart_model u_cart (.*);
	// 4 ns clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// hang guard, the run needs under two hundred cycles
	always @(posedge clk)
		if (++cyc == 3000)
		begin
			n_fail++;
			report_and_stop();
		end
	task automatic chk(input logic [31:0] act, input logic [31:0] exp);
		cmp_count++;
		if (act !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: %h vs %h", $time, act, exp);
		end
	endtask : chk
	// one-cycle strobes with an idle cycle after, so no signal is set twice per step
	task automatic bw(input logic [31:0] a, input logic [31:0] d);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus_req <= '0;
		@(posedge clk);
	endtask : bw
	task automatic br(input logic [31:0] a, input logic [31:0] exp);
		bus_req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1 chk(rdata, exp);
		@(posedge clk);
	endtask : br
	task automatic wait_on(ref logic s, input logic v);
		repeat (60) if (s !== v) @(posedge clk) #1;
		chk(s, v);
		@(posedge clk);
	endtask : wait_on
	task automatic report_and_stop;
		$display("%0d compares, %0d mismatches", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		ack_en = 1'b1;
		bus_req = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (rows[k])
		begin
			bw(cbh_pkg::ADDR_OUT_LATCH, {24'h0, rows[k].o});
			chk(cart_out_bits, rows[k].o);
			chk(tristate_line_o, rows[k].o[0]);
			wait_on(output_ready_flag, 1'b0);
			chk(got, rows[k].o);
			u_cart.send(rows[k].i);
			wait_on(input_ready_flag, 1'b1);
			br(cbh_pkg::ADDR_STATUS, 32'h5);
			br(cbh_pkg::ADDR_IN_BYTE, {24'h0, rows[k].i});
			chk(input_ready_flag, 1'b0);
			$display("row %0d done", k);
		end
		// tristate pin driven from bit 0, then released to the pull-up
		bw(cbh_pkg::ADDR_TRI_CTRL, 32'h1);
		chk(tristate_line_oe_n, 1'b0);
		bw(cbh_pkg::ADDR_OUT_LATCH, 32'h80);
		wait_on(output_ready_flag, 1'b0);
		chk(got, 8'h80);
		br(cbh_pkg::ADDR_STATUS, 32'h0);
		bw(cbh_pkg::ADDR_TRI_CTRL, 32'h0);
		chk(tristate_line_oe_n, 1'b1);
		repeat (2) @(posedge clk);
		br(cbh_pkg::ADDR_STATUS, 32'h4);
		$display("tristate done");
		// serial held until clear-to-send, then unmapped read
		bw(cbh_pkg::ADDR_SER_DIV, 32'h1);
		bw(cbh_pkg::ADDR_SER_DATA, 32'h0);
		repeat (20) @(posedge clk);
		chk(aux_tx, 1'b1);
		br(cbh_pkg::ADDR_STATUS, 32'hc);
		bw(cbh_pkg::ADDR_SER_CTRL, 32'h1);
		chk(aux_rts_n, 1'b0);
		wait_on(aux_tx, 1'b0);
		br(32'h1f40_0020, 32'h0);
		$display("serial done");
		// interrupt masked, raised, cleared
		bw(cbh_pkg::ADDR_IRQ_STAT, 32'h7);
		u_cart.send(8'h77);
		repeat (6) @(posedge clk);
		chk(irq, 1'b0);
		bw(cbh_pkg::ADDR_IRQ_MASK, 32'h1);
		wait_on(irq, 1'b1);
		bw(cbh_pkg::ADDR_IRQ_STAT, 32'h1);
		wait_on(irq, 1'b0);
		$display("irq done");
		// stalled cartridge: write 81 over 80, overwrite with 42, then reset
		ack_en <= 1'b0;
		bw(cbh_pkg::ADDR_OUT_LATCH, 32'h81);
		chk(output_ready_flag, 1'b1);
		bw(cbh_pkg::ADDR_OUT_LATCH, 32'h42);
		repeat (8) @(posedge clk);
		chk(cart_out_bits, 8'h42);
		chk(output_ready_flag, 1'b1);
		rst_n <= 1'b0;
		@(posedge clk);
		chk(output_ready_flag, 1'b0);
		chk(input_ready_flag, 1'b0);
		rst_n <= 1'b1;
		@(posedge clk);
		$display("reset done");
		report_and_stop();
	end
endmodule : tb_cbh_cart_port
